// File: hdl/warmup_pkg.sv
// Purpose: shared constants of the oscillator warm-up counter
// Assumes: 8-bit control/compare registers behind a 32-bit AXI4-Lite slave
// Notes: warm-up times count periods of the selected source clock
package warmup_pkg;
  // ==========================================================
  // widths
  localparam int unsigned CNT_W = 16;
  localparam int unsigned REG_W = 8;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_LOWER_CTRL = 8'h00;
  localparam logic [7:0] ADDR_UPPER_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CMP_LO = 8'h08;
  localparam logic [7:0] ADDR_CMP_HI = 8'h0c;
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_COUNT = 8'h1c;
  // ==========================================================
  // counter control fields
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned RUN_BIT = 3;
  localparam int unsigned SRC_LSB = 4;
  localparam int unsigned SRC_W = 3;
  localparam int unsigned TFF_BIT = 7;
  localparam logic [2:0] MODE_WARMUP = 3'h5;
  localparam logic [2:0] MODE_CASCADE16 = 3'h3;
  localparam logic [2:0] SRC_LOW_FREQ = 3'h4;
  localparam logic [2:0] SRC_HIGH_FREQ = 3'h6;
  localparam logic [7:0] UPPER_WARMUP_IDLE = 8'h05;
  localparam logic [7:0] LOWER_LF_CASCADE = 8'h43;
  localparam logic [7:0] LOWER_HF_CASCADE = 8'h63;
  // ==========================================================
  // system clock control fields and interrupt status bit
  localparam int unsigned SYS_SEL_BIT = 5;
  localparam int unsigned SYS_SLOW_BIT = 6;
  localparam int unsigned SYS_FAST_BIT = 7;
  localparam int unsigned STAT_MATCH_BIT = 0;
  // ==========================================================
  // reset values and the fixed low compare byte
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'hff;
  localparam logic [7:0] SYS_CTRL_RST = 8'h80;
  localparam logic [7:0] LOW_BYTE_IGNORED = 8'h00;
  // ==========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // warm-up figures: compare values in source periods, source clock rate and resulting warm-up times
  localparam logic [15:0] WARMUP_MIN_CMP = 16'h0100;
  localparam logic [15:0] WARMUP_MAX_CMP = 16'hff00;
  localparam int unsigned LF_CLOCK_HZ = 32768;
  localparam int unsigned LF_MIN_WARMUP_US = 7810;
  localparam int unsigned LF_MAX_WARMUP_MS = 1990;
  localparam int unsigned HF_MIN_WARMUP_US = 16;
  localparam int unsigned HF_MAX_WARMUP_US = 4080;
endpackage

// File: hdl/warmup_ctr_if.sv
// Purpose: link between register front end and 16-bit warm-up counter
// Assumes: one clock domain
// Notes: tick is a one-cycle enable of the selected source clock
`timescale 1ns/10ps
interface warmup_ctr_if;
  logic run;
  logic en;
  logic tick;
  logic [7:0] cmp_hi;
  logic [15:0] count;
  logic match;
  modport ctrl (output run, en, tick, cmp_hi, input count, match);
  modport core (input run, en, tick, cmp_hi, output count, match);
endinterface

// File: hdl/warmup_counter_core.sv
// Purpose: cascaded 16-bit up-counter with upper-byte compare
// Assumes: compare value kept steady while running
// Notes: match is a one-cycle pulse, counter cleared at the same edge
`timescale 1ns/10ps
module warmup_counter_core
  import warmup_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control side
  warmup_ctr_if.core cif
);
  // ==========================================================
  // counter
  logic [CNT_W-1:0] count_q;
  logic match_q;
  logic [CNT_W-1:0] target;
  logic step;
  logic hit;

  // only the upper byte takes part in the compare
  assign target = {cif.cmp_hi, LOW_BYTE_IGNORED};
  assign step = cif.run & cif.en & cif.tick;
  assign hit = (CNT_W'(count_q + 1'b1) == target);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else if (!cif.run) begin
      count_q <= '0;
    end else if (step) begin
      if (hit) begin
        count_q <= '0;
      end else begin
        count_q <= CNT_W'(count_q + 1'b1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_q <= 1'b0;
    end else begin
      match_q <= step & hit;
    end
  end

  assign cif.count = count_q;
  assign cif.match = match_q;

  // ==========================================================
  // checks
  logic [CNT_W:0] since_q;
  logic [CNT_W:0] target_full;
  assign target_full = (cif.cmp_hi == LOW_BYTE_IGNORED) ?
                       {1'b1, {CNT_W{1'b0}}} : {1'b0, target};

  // source periods since start, independent of count_q
  always_ff @(posedge aclk) begin
    if (!aresetn || !cif.run) begin
      since_q <= '0;
    end else if (match_q) begin
      since_q <= (CNT_W+1)'(step);
    end else if (step) begin
      since_q <= (CNT_W+1)'(since_q + 1'b1);
    end
  end

  AST_HOLD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    !cif.run |=> (count_q == '0) && !match_q)
    else $error("counter not held at zero while stopped");
  AST_COUNT_UP: assert property (@(posedge aclk) disable iff (!aresetn)
    (step && !hit) |=> count_q == CNT_W'($past(count_q) + 1'b1))
    else $error("counter did not step by one");
  AST_HI_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    match_q |-> $past(count_q[7:0]) == 8'hff &&
                CNT_W'($past(count_q) + 1'b1) == $past(target))
    else $error("match not at upper-byte compare");
  AST_MATCH_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    (step && hit) |=> match_q && (count_q == '0))
    else $error("match did not clear counter and pulse");
  AST_DURATION: assert property (@(posedge aclk) disable iff (!aresetn)
    match_q |-> since_q == target_full)
    else $error("warm-up length differs from compare setting");
  COV_MIN: cover property (@(posedge aclk) disable iff (!aresetn)
    step && hit && target == WARMUP_MIN_CMP);
  COV_MAX: cover property (@(posedge aclk) disable iff (!aresetn)
    step && hit && target == WARMUP_MAX_CMP);
endmodule

// File: hdl/oscillator_warmup_counter.sv
// Purpose: warm-up counter mode of two cascaded 8-bit timers, AXI4-Lite
// Assumes: low/high_freq_tick are one-cycle enables synchronous to aclk
// Notes: the clock switch itself is done by software via system_clock_ctrl
`timescale 1ns/10ps
module oscillator_warmup_counter
  import warmup_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // source clock ticks
  input wire logic low_freq_tick,
  input wire logic high_freq_tick,
  // interrupt and oscillator control
  output logic upper_timer_irq,
  output logic sysclk_sel,
  output logic slow_osc_en,
  output logic fast_osc_en
);
  // ==========================================================
  // write channels
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] waddr_q;
  logic [REG_W-1:0] wbyte_q;
  logic wlane_q;
  logic do_write;

  // both halves may arrive in either order; hold each until paired
  assign do_write = aw_full_q & w_full_q & ~bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_full_q <= 1'b0;
      waddr_q <= '0;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      waddr_q <= awaddr[7:0];
    end else if (bvalid_q && bready) begin
      awready_q <= 1'b1;
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_full_q <= 1'b0;
      wbyte_q <= '0;
      wlane_q <= 1'b0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      wbyte_q <= wdata[REG_W-1:0];
      wlane_q <= wstrb[0];
    end else if (bvalid_q && bready) begin
      wready_q <= 1'b1;
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_known(waddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      ADDR_LOWER_CTRL, ADDR_UPPER_CTRL, ADDR_CMP_LO, ADDR_CMP_HI,
      ADDR_SYS_CTRL, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_COUNT: begin
        addr_known = 1'b1;
      end
      default: begin
        addr_known = 1'b0;
      end
    endcase
  endfunction

  // ==========================================================
  // registers
  logic [REG_W-1:0] lower_counter_ctrl_q;
  logic [REG_W-1:0] upper_counter_ctrl_q;
  logic [REG_W-1:0] warmup_compare_lo_q;
  logic [REG_W-1:0] warmup_compare_hi_q;
  logic [REG_W-1:0] system_clock_ctrl_q;
  logic irq_mask_q;
  logic match_status_q;
  logic upper_timer_irq_q;

  function automatic logic wr_hit(input logic [7:0] a,
                                  input logic [7:0] waddr,
                                  input logic go,
                                  input logic lane);
    wr_hit = go & lane & (waddr == a);
  endfunction

  // writes to run bit take effect on both counters at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_counter_ctrl_q <= CTRL_RST;
    end else if (wr_hit(ADDR_UPPER_CTRL, waddr_q, do_write, wlane_q)) begin
      upper_counter_ctrl_q <= wbyte_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lower_counter_ctrl_q <= CTRL_RST;
    end else if (wr_hit(ADDR_LOWER_CTRL, waddr_q, do_write, wlane_q)) begin
      lower_counter_ctrl_q <= wbyte_q;
    end
  end

  // low byte is stored and read back but never compared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warmup_compare_lo_q <= CMP_RST;
      warmup_compare_hi_q <= CMP_RST;
    end else begin
      if (wr_hit(ADDR_CMP_LO, waddr_q, do_write, wlane_q)) begin
        warmup_compare_lo_q <= wbyte_q;
      end
      if (wr_hit(ADDR_CMP_HI, waddr_q, do_write, wlane_q)) begin
        warmup_compare_hi_q <= wbyte_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_clock_ctrl_q <= SYS_CTRL_RST;
    end else if (wr_hit(ADDR_SYS_CTRL, waddr_q, do_write, wlane_q)) begin
      system_clock_ctrl_q <= wbyte_q;
    end
  end

  // ==========================================================
  // counter control decode
  warmup_ctr_if cif ();
  logic [MODE_W-1:0] upper_mode;
  logic [MODE_W-1:0] lower_mode;
  logic [SRC_W-1:0] lower_src;

  assign upper_mode = upper_counter_ctrl_q[MODE_LSB +: MODE_W];
  assign lower_mode = lower_counter_ctrl_q[MODE_LSB +: MODE_W];
  assign lower_src = lower_counter_ctrl_q[SRC_LSB +: SRC_W];
  assign cif.run = upper_counter_ctrl_q[RUN_BIT];
  // other timer modes are not built: those settings leave it idle
  assign cif.en = (upper_mode == MODE_WARMUP) &&
                  (lower_mode == MODE_CASCADE16);
  assign cif.cmp_hi = warmup_compare_hi_q;
  assign cif.tick = (lower_src == SRC_LOW_FREQ) ? low_freq_tick :
                    (lower_src == SRC_HIGH_FREQ) ? high_freq_tick : 1'b0;

  warmup_counter_core u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .cif(cif.core)
  );

  // ==========================================================
  // interrupt: sticky status, write one to clear, set wins
  logic match_clr;
  assign match_clr = wr_hit(ADDR_IRQ_STATUS, waddr_q, do_write, wlane_q) &
                     wbyte_q[STAT_MATCH_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_status_q <= 1'b0;
    end else begin
      match_status_q <= (match_status_q & ~match_clr) | cif.match;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= 1'b0;
    end else if (wr_hit(ADDR_IRQ_MASK, waddr_q, do_write, wlane_q)) begin
      irq_mask_q <= wbyte_q[STAT_MATCH_BIT];
    end
  end

  // registered for a clean output; one cycle behind status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_timer_irq_q <= 1'b0;
    end else begin
      upper_timer_irq_q <= match_status_q & irq_mask_q;
    end
  end

  // ==========================================================
  // read channel
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    case (araddr[7:0])
      ADDR_LOWER_CTRL: rd_word[REG_W-1:0] = lower_counter_ctrl_q;
      ADDR_UPPER_CTRL: rd_word[REG_W-1:0] = upper_counter_ctrl_q;
      ADDR_CMP_LO: rd_word[REG_W-1:0] = warmup_compare_lo_q;
      ADDR_CMP_HI: rd_word[REG_W-1:0] = warmup_compare_hi_q;
      ADDR_SYS_CTRL: rd_word[REG_W-1:0] = system_clock_ctrl_q;
      ADDR_IRQ_STATUS: rd_word[STAT_MATCH_BIT] = match_status_q;
      ADDR_IRQ_MASK: rd_word[STAT_MATCH_BIT] = irq_mask_q;
      ADDR_COUNT: rd_word[CNT_W-1:0] = cif.count;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= addr_known(araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign upper_timer_irq = upper_timer_irq_q;
  assign sysclk_sel = system_clock_ctrl_q[SYS_SEL_BIT];
  assign slow_osc_en = system_clock_ctrl_q[SYS_SLOW_BIT];
  assign fast_osc_en = system_clock_ctrl_q[SYS_FAST_BIT];

  // ==========================================================
  // checks
  AST_MODE_DECODE: assert property (@(posedge aclk) disable iff (!aresetn)
    upper_counter_ctrl_q == UPPER_WARMUP_IDLE |->
      upper_mode == MODE_WARMUP && !cif.run &&
      !upper_counter_ctrl_q[TFF_BIT])
    else $error("upper control decode wrong");
  AST_SRC_SLOW: assert property (@(posedge aclk) disable iff (!aresetn)
    (lower_counter_ctrl_q == LOWER_LF_CASCADE &&
     upper_mode == MODE_WARMUP) |->
      cif.en && cif.tick == low_freq_tick && !cif.tick == !low_freq_tick)
    else $error("slow cascade not clocked by slow source");
  AST_SRC_FAST: assert property (@(posedge aclk) disable iff (!aresetn)
    (lower_counter_ctrl_q == LOWER_HF_CASCADE &&
     upper_mode == MODE_WARMUP) |-> cif.en && cif.tick == high_freq_tick)
    else $error("fast cascade not clocked by fast source");
  AST_SYS_BITS: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_hit(ADDR_SYS_CTRL, waddr_q, do_write, wlane_q) |=>
      sysclk_sel == $past(wbyte_q[SYS_SEL_BIT]) &&
      slow_osc_en == $past(wbyte_q[SYS_SLOW_BIT]) &&
      fast_osc_en == $past(wbyte_q[SYS_FAST_BIT]))
    else $error("system clock control bits misplaced");
  AST_RUN_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(cif.run) |-> ##1 (cif.count == '0) [*2])
    else $error("stop did not clear both counters");
  AST_IRQ_PATH: assert property (@(posedge aclk) disable iff (!aresetn)
    (cif.match && irq_mask_q &&
     !wr_hit(ADDR_IRQ_MASK, waddr_q, do_write, wlane_q)) |=>
      ##1 upper_timer_irq)
    else $error("match did not raise interrupt");
  COV_SLOW_MATCH: cover property (@(posedge aclk) disable iff (!aresetn)
    cif.match && lower_src == SRC_LOW_FREQ);
  COV_FAST_MATCH: cover property (@(posedge aclk) disable iff (!aresetn)
    cif.match && lower_src == SRC_HIGH_FREQ);
  COV_CLEAR_RACE: cover property (@(posedge aclk) disable iff (!aresetn)
    cif.match && match_clr);
endmodule

// File: sim/tb.sv
// Purpose: self-checking bench for the oscillator warm-up counter
// Assumes: axi4-lite master, ticks driven as one-cycle enables
// Notes: expected bus answers queued by driver, popped by monitor
`timescale 1ns/10ps
module tb;
  import warmup_pkg::*;
  // ==========================================================
  // signals
  typedef struct {logic [31:0] d; logic [1:0] r;} exp_s;
  logic aclk = 1'b0;
  logic aresetn;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic lf_tick, hf_tick;
  logic irq, sysclk_sel, slow_osc_en, fast_osc_en;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed;
  exp_s rq[$];
  exp_s wq[$];
  exp_s e;
  logic [7:0] lo_byte;
  logic [7:0] ra [8] = '{ADDR_LOWER_CTRL, ADDR_UPPER_CTRL, ADDR_CMP_LO,
    ADDR_CMP_HI, ADDR_SYS_CTRL, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_COUNT};
  logic [7:0] rv [8] = '{CTRL_RST, CTRL_RST, CMP_RST, CMP_RST,
    SYS_CTRL_RST, 8'h00, 8'h00, 8'h00};

  always #5 aclk = ~aclk;

  oscillator_warmup_counter i_oscillator_warmup_counter (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .low_freq_tick(lf_tick), .high_freq_tick(hf_tick),
    .upper_timer_irq(irq), .sysclk_sel(sysclk_sel),
    .slow_osc_en(slow_osc_en), .fast_osc_en(fast_osc_en)
  );

  // ==========================================================
  // compare and report
  task automatic chk32(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, got);
    end
  endtask

  task automatic chk1(input string nm, input logic ex, input logic got);
    checks_done++;
    if (got !== ex) begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", nm, ex, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // longest run is one full-scale fast warm-up plus bus traffic
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      $display("unexpected cycles: expected below 90000, seen 90000");
      end_of_test();
    end
  end

  // monitor: answers taken at the handshake edge
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      if (rq.size() == 0) begin
        n_fail++;
        $display("unexpected rvalid: expected 0, seen 1");
      end else begin
        e = rq.pop_front();
        chk32("rdata", e.d, rdata);
        chk32("rresp", {30'h0, e.r}, {30'h0, rresp});
      end
    end
    if (bvalid && bready) begin
      if (wq.size() == 0) begin
        n_fail++;
        $display("unexpected bvalid: expected 0, seen 1");
      end else begin
        e = wq.pop_front();
        chk32("bresp", {30'h0, e.r}, {30'h0, bresp});
      end
    end
  end

  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s = 4'hf,
                    input logic [1:0] er = RESP_OKAY);
    bit aw;
    bit w;
    logic [31:0] r;
    aw = 0;
    w = 0;
    r = $urandom();
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {r[31:8], d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wq.push_back('{32'h0, er});
    forever begin
      @(posedge aclk);
      if (awready && !aw) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wready && !w) begin
        w = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er = RESP_OKAY);
    bit ar;
    ar = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back('{ed, er});
    forever begin
      @(posedge aclk);
      if (arready && !ar) begin
        ar = 1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // tick pulses; gappy spaces them out by random idle cycles
  task automatic ticks(input bit fast, input int n, input bit gappy);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      if (fast) hf_tick <= 1'b1;
      else lf_tick <= 1'b1;
      if (gappy) begin
        @(posedge aclk);
        lf_tick <= 1'b0;
        hf_tick <= 1'b0;
        repeat ($urandom_range(2)) @(posedge aclk);
      end
    end
    @(posedge aclk);
    lf_tick <= 1'b0;
    hf_tick <= 1'b0;
  endtask

  // last tick then one-cycle status lag, then irq
  task automatic last_tick(input bit fast, input logic ex);
    ticks(fast, 1, 0);
    @(posedge aclk);
    #1;
    chk1("irq_lag", 1'b0, irq);
    @(posedge aclk);
    #1;
    chk1("irq", ex, irq);
  endtask

  task automatic pins(input logic s, input logic lo, input logic hi);
    #1;
    chk1("sysclk_sel", s, sysclk_sel);
    chk1("slow_osc_en", lo, slow_osc_en);
    chk1("fast_osc_en", hi, fast_osc_en);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, lf_tick, hf_tick} = '0;
    seed = $urandom(22);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    pins(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) rd(ra[i], {24'h0, rv[i]});
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h05, 8'h12, 4'hf, RESP_SLVERR);
    wr(ADDR_CMP_LO, 8'h12, 4'he);
    rd(ADDR_CMP_LO, {24'h0, CMP_RST});
    // slow warm-up at minimum compare, lower byte must not matter
    lo_byte = 8'($urandom_range(255));
    wr(ADDR_SYS_CTRL, 8'hc0);
    pins(1'b0, 1'b1, 1'b1);
    wr(ADDR_CMP_LO, lo_byte);
    wr(ADDR_CMP_HI, 8'h01);
    wr(ADDR_LOWER_CTRL, LOWER_LF_CASCADE);
    wr(ADDR_UPPER_CTRL, UPPER_WARMUP_IDLE);
    ticks(0, 3, 1);
    rd(ADDR_COUNT, 32'h0);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_UPPER_CTRL, 8'h0d);
    ticks(0, 255, 1);
    ticks(1, 5, 0);
    rd(ADDR_COUNT, 32'h000000ff);
    last_tick(0, 1'b1);
    rd(ADDR_COUNT, 32'h0);
    ticks(0, 2, 1);
    wr(ADDR_UPPER_CTRL, UPPER_WARMUP_IDLE);
    rd(ADDR_COUNT, 32'h0);
    ticks(0, 4, 1);
    rd(ADDR_COUNT, 32'h0);
    wr(ADDR_SYS_CTRL, 8'he0);
    wr(ADDR_SYS_CTRL, 8'h60);
    pins(1'b1, 1'b1, 1'b0);
    rd(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge aclk);
    pins(1'b1, 1'b1, 1'b0);
    chk1("irq_clear", 1'b0, irq);
    // fast warm-up at maximum compare
    wr(ADDR_SYS_CTRL, 8'he0);
    pins(1'b1, 1'b1, 1'b1);
    wr(ADDR_LOWER_CTRL, LOWER_HF_CASCADE);
    wr(ADDR_CMP_HI, 8'hff);
    wr(ADDR_UPPER_CTRL, 8'h0d);
    ticks(1, 16'hfeff, 0);
    ticks(0, 3, 1);
    rd(ADDR_COUNT, 32'h0000feff);
    chk1("irq_early", 1'b0, irq);
    last_tick(1, 1'b1);
    wr(ADDR_UPPER_CTRL, UPPER_WARMUP_IDLE);
    wr(ADDR_SYS_CTRL, 8'hc0);
    wr(ADDR_SYS_CTRL, 8'h80);
    pins(1'b0, 1'b0, 1'b1);
    wr(ADDR_IRQ_STATUS, 8'h01);
    // masked match: status sets, irq waits for mask
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_CMP_HI, 8'h01);
    wr(ADDR_UPPER_CTRL, 8'h0d);
    ticks(1, 255, 0);
    last_tick(1, 1'b0);
    rd(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge aclk);
    #1;
    chk1("irq_unmask", 1'b1, irq);
    wr(ADDR_UPPER_CTRL, UPPER_WARMUP_IDLE);
    wr(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge aclk);
    #1;
    chk1("irq_clear", 1'b0, irq);
    rd(ADDR_IRQ_STATUS, 32'h0);
    repeat (3) @(posedge aclk);
    end_of_test();
  end
endmodule
